// ---- inc/fpl_regs.svh ----
// register offsets, reset values and timing counts of the panel indicator block
`ifndef FPL_REGS_SVH
`define FPL_REGS_SVH

`define FPL_ADDR_W          4
`define FPL_OFF_CTRL        4'h0
`define FPL_OFF_CODE        4'h1
`define FPL_OFF_STAT        4'h2
`define FPL_OFF_IRQ_STAT    4'h3
`define FPL_OFF_IRQ_MASK    4'h4

`define FPL_CTRL_IDENT_BIT  0
`define FPL_CTRL_RST        8'h00
`define FPL_CODE_RST        8'h00
`define FPL_IRQ_MASK_RST    8'h00

`define FPL_IRQ_CRIT_BIT    0
`define FPL_IRQ_NCRIT_BIT   1
`define FPL_IRQ_CODE_BIT    2
`define FPL_IRQ_W           3

`define FPL_BLINK_MS        500
`define FPL_CLK_MHZ         250
`define FPL_BLINK_CYC       (`FPL_BLINK_MS * 1000 * `FPL_CLK_MHZ)

`endif

// ---- inc/fpl_pkg.sv ----
// types of the panel indicator block
package fpl_pkg;

	typedef enum logic [1:0] {
		FPL_PWR_ON    = 2'b00,
		FPL_PWR_LIGHT = 2'b01,
		FPL_PWR_OFF   = 2'b10
	} fpl_pwr_t;

	typedef struct packed {
		logic ac_present;
		logic ready;
		logic degraded;
		logic noncrit;
		logic critical;
		logic regulator_alert;
		logic fans_short;
	} fpl_cond_t;

	typedef enum logic [2:0] {
		FPL_ST_OFF    = 3'b000,
		FPL_ST_GREEN  = 3'b001,
		FPL_ST_GBLINK = 3'b010,
		FPL_ST_ABLINK = 3'b011,
		FPL_ST_AMBER  = 3'b100
	} fpl_stat_t;

	typedef struct packed {
		logic power_green;
		logic status_green;
		logic status_amber;
		logic disk_green;
		logic ident_blue;
	} fpl_leds_t;

endpackage

// ---- hdl/fpl_front_panel.sv ----
// front panel and diagnostic indicator driver
`include "fpl_regs.svh"

module fpl_front_panel
	import fpl_pkg::*;
#(
	parameter int BLINK_CYC = `FPL_BLINK_CYC
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_sys_rst,
	// system state
	input  wire fpl_pkg::fpl_pwr_t       i_pwr_state,
	input  wire fpl_pkg::fpl_cond_t      i_cond,
	input  wire logic                    i_disk_busy,
	input  wire logic                    i_ident_button,
	// register port
	input  wire logic [`FPL_ADDR_W-1:0]  i_addr,
	input  wire logic [7:0]              i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic      [7:0]              o_rdata,
	// indicators
	output fpl_pkg::fpl_leds_t           o_leds,
	output logic      [7:0]              o_diag,
	output logic                         o_irq
);
	import fpl_pkg::*;

	localparam int CW = $clog2(BLINK_CYC + 1);
	localparam logic [7:0] IMASK_RST = `FPL_IRQ_MASK_RST;

	// pin synchronisers
	logic [1:0]  pwr_s1_q, pwr_s2_q;
	fpl_cond_t   cond_s1_q, cond_s2_q;
	logic [1:0]  misc_s1_q, misc_s2_q;
	logic        disk_s, btn_s;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pwr_s1_q  <= 2'h2;
			pwr_s2_q  <= 2'h2;
			cond_s1_q <= '0;
			cond_s2_q <= '0;
			misc_s1_q <= 2'h0;
			misc_s2_q <= 2'h0;
		end else begin
			pwr_s1_q  <= i_pwr_state;
			pwr_s2_q  <= pwr_s1_q;
			cond_s1_q <= i_cond;
			cond_s2_q <= cond_s1_q;
			misc_s1_q <= {i_ident_button, i_disk_busy};
			misc_s2_q <= misc_s1_q;
		end
	end
	assign disk_s = misc_s2_q[0];
	assign btn_s  = misc_s2_q[1];

	// shared blink divider
	logic [CW-1:0] div_q, div_d;
	logic          blink_q, blink_d;

	always_comb begin
		div_d   = div_q + CW'(1);
		blink_d = blink_q;
		if (div_q == CW'(BLINK_CYC - 1)) begin
			div_d   = '0;
			blink_d = ~blink_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			div_q   <= '0;
			blink_q <= 1'b0;
		end else begin
			div_q   <= div_d;
			blink_q <= blink_d;
		end
	end

	// registers and interrupts
	logic [7:0]           ctrl_q, ctrl_d, code_q, code_d;
	logic [`FPL_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
	logic [7:0]           rdata_d;
	logic                 crit_prev_q, ncrit_prev_q;
	logic                 crit_now, ncrit_now, code_wr;

	assign crit_now  = cond_s2_q.critical;
	assign ncrit_now = cond_s2_q.noncrit | cond_s2_q.regulator_alert
		| cond_s2_q.fans_short;
	assign code_wr = i_wr && (i_addr == `FPL_OFF_CODE);

	always_comb begin
		ev = '0;
		ev[`FPL_IRQ_CRIT_BIT]  = crit_now & ~crit_prev_q;
		ev[`FPL_IRQ_NCRIT_BIT] = ncrit_now & ~ncrit_prev_q;
		ev[`FPL_IRQ_CODE_BIT]  = code_wr;
		ctrl_d  = ctrl_q;
		code_d  = code_q;
		imask_d = imask_q;
		ist_d   = ist_q;
		if (i_wr) begin
			case (i_addr)
				`FPL_OFF_CTRL:     ctrl_d  = i_wdata;
				`FPL_OFF_CODE:     code_d  = i_wdata;
				`FPL_OFF_IRQ_STAT: ist_d   = ist_q & ~i_wdata[`FPL_IRQ_W-1:0];
				`FPL_OFF_IRQ_MASK: imask_d = i_wdata[`FPL_IRQ_W-1:0];
				default:           ;
			endcase
		end
		ist_d = ist_d | ev;
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`FPL_OFF_CTRL:     rdata_d = ctrl_q;
				`FPL_OFF_CODE:     rdata_d = code_q;
				`FPL_OFF_STAT:     rdata_d = {3'h0, o_leds};
				`FPL_OFF_IRQ_STAT: rdata_d = {5'h0, ist_q};
				`FPL_OFF_IRQ_MASK: rdata_d = {5'h0, imask_q};
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_q       <= `FPL_CTRL_RST;
			code_q       <= `FPL_CODE_RST;
			imask_q      <= IMASK_RST[`FPL_IRQ_W-1:0];
			ist_q        <= '0;
			o_rdata      <= 8'h00;
			crit_prev_q  <= 1'b0;
			ncrit_prev_q <= 1'b0;
		end else begin
			ctrl_q       <= ctrl_d;
			code_q       <= code_d;
			imask_q      <= imask_d;
			ist_q        <= ist_d;
			o_rdata      <= rdata_d;
			crit_prev_q  <= crit_now;
			ncrit_prev_q <= ncrit_now;
		end
	end

	assign o_irq = |(ist_q & imask_q);

	// recorded condition since power loss
	logic seen_q, seen_d;
	always_comb begin
		seen_d = seen_q | crit_now | ncrit_now | cond_s2_q.degraded;
		if (!cond_s2_q.ac_present)
			seen_d = 1'b0;
	end

	// status selection
	fpl_stat_t stat_sel;
	logic      standby;
	assign standby = (fpl_pwr_t'(pwr_s2_q) != FPL_PWR_ON);

	always_comb begin
		if (!cond_s2_q.ac_present)
			stat_sel = FPL_ST_OFF;
		else if (crit_now)
			stat_sel = FPL_ST_AMBER;
		else if (ncrit_now)
			stat_sel = FPL_ST_ABLINK;
		else if (cond_s2_q.degraded)
			stat_sel = FPL_ST_GBLINK;
		else if (standby && !seen_q)
			stat_sel = FPL_ST_OFF;
		else if (cond_s2_q.ready)
			stat_sel = FPL_ST_GREEN;
		else
			stat_sel = FPL_ST_OFF;
	end

	// indicator outputs
	fpl_leds_t leds_d;
	logic [7:0] diag_d;

	always_comb begin
		leds_d = '0;
		case (fpl_pwr_t'(pwr_s2_q))
			FPL_PWR_ON:    leds_d.power_green = 1'b1;
			FPL_PWR_LIGHT: leds_d.power_green = blink_q;
			default:       leds_d.power_green = 1'b0;
		endcase
		case (stat_sel)
			FPL_ST_GREEN:  leds_d.status_green = 1'b1;
			FPL_ST_GBLINK: leds_d.status_green = blink_q;
			FPL_ST_AMBER:  leds_d.status_amber = 1'b1;
			FPL_ST_ABLINK: leds_d.status_amber = blink_q;
			default:       ;
		endcase
		leds_d.disk_green = disk_s & blink_q;
		if (btn_s)
			leds_d.ident_blue = 1'b1;
		else if (ctrl_q[`FPL_CTRL_IDENT_BIT])
			leds_d.ident_blue = blink_q;
		for (int i = 0; i < 8; i++)
			diag_d[i] = code_q[i];
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_leds <= '0;
			o_diag <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			o_leds <= leds_d;
			o_diag <= diag_d;
			seen_q <= seen_d;
		end
	end

	// checks
	a_amber_steady: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(stat_sel == FPL_ST_AMBER) |=> o_leds.status_amber)
		else $error("critical alarm not steady amber");
	a_crit_wins: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(cond_s2_q.ac_present && crit_now) |=> !o_leds.status_green)
		else $error("green shown during critical alarm");
	a_no_ac_off: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		!cond_s2_q.ac_present
		|=> !o_leds.status_green && !o_leds.status_amber)
		else $error("status lit without power");
	a_standby_off: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(cond_s2_q.ac_present && !crit_now && !ncrit_now
		&& !cond_s2_q.degraded && standby && !seen_q)
		|=> !o_leds.status_green && !o_leds.status_amber)
		else $error("status lit in standby with none recorded");
	a_green_steady: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(stat_sel == FPL_ST_GREEN) |=> o_leds.status_green)
		else $error("ready not steady green");
	a_green_blink: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(stat_sel == FPL_ST_GBLINK)
		|=> o_leds.status_green == $past(blink_q))
		else $error("degraded not blinking green");
	a_ncrit_amber: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(cond_s2_q.ac_present && !crit_now && ncrit_now)
		|=> !o_leds.status_green)
		else $error("green shown during non-critical failure");
	a_pwr_on: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(pwr_s2_q == FPL_PWR_ON) |=> o_leds.power_green)
		else $error("power not lit when on");
	a_pwr_blink: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(pwr_s2_q == FPL_PWR_LIGHT)
		|=> o_leds.power_green == $past(blink_q))
		else $error("power not blinking in sleep");
	a_pwr_off: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(pwr_s2_q == FPL_PWR_OFF) |=> !o_leds.power_green)
		else $error("power lit when off");
	a_disk_idle: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		!disk_s |=> !o_leds.disk_green)
		else $error("disk lit with no access");
	a_disk_blink: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		disk_s |=> o_leds.disk_green == $past(blink_q))
		else $error("disk not blinking on access");
	a_ident_btn: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		btn_s |=> o_leds.ident_blue)
		else $error("ident not lit on button");
	a_ident_idle: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!btn_s && !ctrl_q[`FPL_CTRL_IDENT_BIT]) |=> !o_leds.ident_blue)
		else $error("ident lit with no request");
	a_ident_soft: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!btn_s && ctrl_q[`FPL_CTRL_IDENT_BIT])
		|=> o_leds.ident_blue == $past(blink_q))
		else $error("ident not blinking on software request");
	a_diag_bits: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		1'b1 |=> o_diag == $past(code_q))
		else $error("progress code bits not mapped");
	a_code_write: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		code_wr |=> ##1 (o_diag == $past(i_wdata, 2)))
		else $error("progress code not shown");
	a_code_hold: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!code_wr && !$past(code_wr)) |=> $stable(o_diag))
		else $error("progress code changed without write");
	a_blink_phase: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(stat_sel == FPL_ST_ABLINK)
		|=> o_leds.status_amber == $past(blink_q))
		else $error("blink out of phase");
	a_crit_irq: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(crit_now && !crit_prev_q) |=> ist_q[`FPL_IRQ_CRIT_BIT])
		else $error("critical event not latched");

endmodule

// ---- test/fpl_bmc_model.sv ----
// board controller and boot firmware model driving the panel block
`include "fpl_regs.svh"
module fpl_bmc_model
	import fpl_pkg::*;
(
	input  wire logic         i_clk,
	input  wire logic [7:0]   i_rdata,
	output fpl_pkg::fpl_pwr_t  o_pwr_state,
	output fpl_pkg::fpl_cond_t o_cond,
	output logic              o_disk_busy,
	output logic              o_ident_button,
	output logic [3:0]        o_addr,
	output logic [7:0]        o_wdata,
	output logic              o_wr,
	output logic              o_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_pwr_state = FPL_PWR_ON;
		o_cond = '0;
		o_disk_busy = 1'b0;
		o_ident_button = 1'b0;
		o_addr = 4'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic set(input fpl_pwr_t p, input logic [6:0] c,
		input logic d, input logic b);
		@(posedge i_clk);
		o_pwr_state <= p;
		o_cond <= c;
		o_disk_busy <= d;
		o_ident_button <= b;
		repeat (6) @(posedge i_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		@(negedge i_clk);
		d = i_rdata;
	endtask
	// progress code at the start of each routine
	task automatic post(input logic [7:0] code);
		wr(`FPL_OFF_CODE, code);
	endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench of the panel indicator block
`include "fpl_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fpl_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	fpl_pwr_t   pwr;
	fpl_cond_t  cond;
	logic       disk, btn, wr, rd, irq;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, diag;
	fpl_leds_t  leds;
	int         n_fail = 0;
	int         check_count = 0;
	always #2 clk = ~clk;
	fpl_front_panel #(.BLINK_CYC(4)) dut_u (.i_clk(clk), .i_sys_rst(rst),
		.i_pwr_state(pwr), .i_cond(cond), .i_disk_busy(disk),
		.i_ident_button(btn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_leds(leds), .o_diag(diag),
		.o_irq(irq));
	fpl_bmc_model bmc_u (.i_clk(clk), .i_rdata(rdata), .o_pwr_state(pwr),
		.o_cond(cond), .o_disk_busy(disk), .o_ident_button(btn),
		.o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one indicator over 16 cycles: 0 off, 1 blink, 2 on, 3 odd rate
	task automatic mode(input int b, input logic [1:0] exp);
		int n;
		n = 0;
		repeat (16) begin
			@(negedge clk);
			n += (leds[b] === 1'b1);
		end
		chk((n == 0) ? 8'h00 : (n == 16) ? 8'h02 : (n == 8) ? 8'h01 : 8'h03,
			{6'h00, exp});
	endtask
	task automatic t_reg(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		bmc_u.rd(a, d);
		chk(d, e);
	endtask
	task automatic t_power();
		fpl_pwr_t p[3] = '{FPL_PWR_ON, FPL_PWR_LIGHT, FPL_PWR_OFF};
		for (int i = 0; i < 3; i++) begin
			bmc_u.set(p[i], 7'h60, 1'b0, 1'b0);
			mode(4, 2'(2 - i));
		end
	endtask
	task automatic t_status();
		logic [6:0] c[8] = '{7'h60, 7'h70, 7'h68, 7'h62, 7'h61, 7'h7c,
			7'h00, 7'h60};
		logic [3:0] e[8] = '{4'h8, 4'h4, 4'h1, 4'h1, 4'h1, 4'h2, 4'h0, 4'h0};
		for (int i = 0; i < 8; i++) begin
			bmc_u.set((i == 7) ? FPL_PWR_LIGHT : FPL_PWR_ON, c[i], 1'b0, 1'b0);
			mode(3, e[i][3:2]);
			mode(2, e[i][1:0]);
		end
	endtask
	task automatic t_act();
		bmc_u.set(FPL_PWR_ON, 7'h60, 1'b1, 1'b1);
		mode(1, 2'h1);
		mode(0, 2'h2);
		bmc_u.wr(`FPL_OFF_CTRL, 8'h01);
		bmc_u.set(FPL_PWR_ON, 7'h60, 1'b1, 1'b0);
		repeat (16) begin
			@(negedge clk);
			chk({7'h00, leds.disk_green}, {7'h00, leds.ident_blue});
		end
		mode(0, 2'h1);
		bmc_u.wr(`FPL_OFF_CTRL, 8'h00);
		bmc_u.set(FPL_PWR_ON, 7'h60, 1'b0, 1'b0);
		mode(1, 2'h0);
		mode(0, 2'h0);
	endtask
	task automatic t_code();
		logic [7:0] v[3] = '{8'h80, 8'h01, 8'ha5};
		t_reg(`FPL_OFF_IRQ_STAT, 8'h03);
		foreach (v[i]) begin
			bmc_u.post(v[i]);
			repeat (20) @(negedge clk);
			chk(diag, v[i]);
		end
		t_reg(`FPL_OFF_CODE, 8'ha5);
		t_reg(`FPL_OFF_STAT, 8'h18);
		t_reg(4'hf, 8'h00);
		chk({7'h00, irq}, 8'h00);
		bmc_u.wr(`FPL_OFF_IRQ_MASK, 8'h04);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		bmc_u.wr(`FPL_OFF_IRQ_STAT, 8'h07);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
		bmc_u.wr(`FPL_OFF_IRQ_MASK, 8'h01);
		bmc_u.set(FPL_PWR_ON, 7'h64, 1'b0, 1'b0);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		t_reg(`FPL_OFF_IRQ_STAT, 8'h01);
		bmc_u.wr(`FPL_OFF_IRQ_MASK, 8'h02);
		bmc_u.set(FPL_PWR_ON, 7'h68, 1'b0, 1'b0);
		t_reg(`FPL_OFF_IRQ_STAT, 8'h03);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		bmc_u.wr(`FPL_OFF_IRQ_STAT, 8'h03);
		bmc_u.set(FPL_PWR_ON, 7'h60, 1'b0, 1'b0);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
		t_reg(`FPL_OFF_IRQ_STAT, 8'h00);
	endtask
	initial begin
		#300000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reg(`FPL_OFF_CTRL, `FPL_CTRL_RST);
		t_reg(`FPL_OFF_CODE, `FPL_CODE_RST);
		t_reg(`FPL_OFF_IRQ_MASK, `FPL_IRQ_MASK_RST);
		t_power();
		t_status();
		t_act();
		t_code();
		stop_test();
	end
endmodule
